// >>> core/bpsc_pkg.sv
/*
 Package for the bridge pre-driver status and configuration bank: register
 addresses, field positions, reset values, operation codes and timing counts.
 Assumes a 100 MHz core clock.
*/
package bpsc_pkg;
   localparam int          FRAME_BITS        = 24;
   localparam logic [5:0]  ADDR_FAULT_STATUS = 6'h10;
   localparam logic [5:0]  ADDR_BRIDGE_CFG   = 6'h3F;
   localparam logic [1:0]  OP_WRITE          = 2'h0;
   localparam logic [1:0]  OP_READ           = 2'h1;
   localparam logic [1:0]  OP_READ_CLEAR     = 2'h2;
   localparam logic [15:0] FAULT_STATUS_RST  = 16'h0000;
   localparam logic [15:0] BRIDGE_CFG_RST    = 16'h0000;
   // Status field positions; the four switch flags are D9..D6
   localparam int          POS_HIGH_SWITCH_ONE = 9;
   localparam int          POS_LOW_SWITCH_ONE  = 8;
   localparam int          POS_HIGH_SWITCH_TWO = 7;
   localparam int          POS_LOW_SWITCH_TWO  = 6;
   localparam int          POS_UNDERVOLTAGE    = 3;
   localparam int          POS_OVERVOLTAGE     = 2;
   localparam logic [15:0] FAULT_STATUS_MASK   = 16'h03CC;
   // Configuration field positions
   localparam int          POS_RISE_DEAD_LSB   = 12;
   localparam int          POS_FALL_DEAD_LSB   = 8;
   localparam int          POS_TRIP_LEVEL_LSB  = 5;
   localparam int          POS_DUAL_HALF       = 4;
   localparam int          POS_GATE_SLEW       = 3;
   localparam logic [15:0] BRIDGE_CFG_MASK     = 16'hFFF8;
   // Dead time is 250 ns per step plus one step
   localparam int          CLK_PERIOD_NS       = 10;
   localparam int          DEAD_STEP_NS        = 250;
   localparam int          DEAD_STEP_CYCLES    = DEAD_STEP_NS / CLK_PERIOD_NS;
   // Trip level in millivolts per code step
   localparam int          TRIP_STEP_MV        = 250;
   // Global status byte bit positions of the combined fault and global fault
   localparam int          GSB_GLOBAL_FAULT    = 7;
   localparam int          GSB_COMBINED_FAULT  = 2;
endpackage

// >>> core/bpsc_sync.sv
/*
 Two-flop synchroniser for a bus of levels.
 Assumes each bit is a slow level, or a value held steady across a capture.
*/
`timescale 1ns/1ps
module bpsc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] q_ff;

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d_in;
         q_ff    <= meta_ff;
      end
   end

   assign q_out = q_ff;
endmodule

// >>> core/bpsc_link.sv
/*
 Serial frame engine on the host's serial clock. Shifts in a 24-bit frame,
 shifts out the global status byte and then the 16-bit read word.
 Assumes chip select is high outside frames; the serial clock idles between
 frames, so frame end is taken from chip select in the core domain.
*/
`timescale 1ns/1ps
module bpsc_link
   import bpsc_pkg::*;
(
   input  wire logic        sclk_in,
   input  wire logic        csn_in,
   input  wire logic        sdi_in,
   input  wire logic [7:0]  status_byte_in,
   input  wire logic [15:0] read_word_in,
   output logic [23:0] frame_out,
   output logic [4:0]  bit_count_out,
   output logic        sdo_out
);
   logic [23:0] shift_in_ff;
   logic [4:0]  count_ff;
   logic [23:0] shift_out_ff;
   logic [23:0] frame_hold_ff;
   logic [4:0]  count_hold_ff;

   // Counter restarts while chip select is high, no edge needed for that
   always_ff @(posedge sclk_in or posedge csn_in) begin
      if (csn_in) begin
         count_ff    <= 5'h00;
         shift_in_ff <= 24'h000000;
      end else begin
         shift_in_ff <= {shift_in_ff[22:0], sdi_in};
         if (count_ff != 5'h1F)
            count_ff <= count_ff + 5'h01;
      end
   end

   // Finished frame is kept from chip select rise so the core can look late;
   // relies on the counter's reset delay exceeding the hold time of these flops
   always_ff @(posedge csn_in) begin
      frame_hold_ff <= shift_in_ff;
      count_hold_ff <= count_ff;
   end

   // Status byte loads at the first fall; the data word waits for the address
   always_ff @(negedge sclk_in or posedge csn_in) begin
      if (csn_in)
         shift_out_ff <= 24'h000000;
      else if (count_ff == 5'h01)
         shift_out_ff <= {status_byte_in[6:0], 17'h00000};
      else if (count_ff == 5'h08)
         shift_out_ff <= {read_word_in, 8'h00};
      else
         shift_out_ff <= {shift_out_ff[22:0], 1'b0};
   end

   assign frame_out     = csn_in ? frame_hold_ff : shift_in_ff;
   assign bit_count_out = count_hold_ff;
   assign sdo_out       = (count_ff == 5'h00) ? status_byte_in[7] : shift_out_ff[23];
endmodule

// >>> core/bpsc_top.sv
/*
 Bridge pre-driver status and configuration bank, core clock domain.
 Holds the fault status and the bridge configuration, gates the four gate
 enables, and services 24-bit serial frames from the host.
 Assumes fault inputs and supply monitors are asynchronous levels, and the
 serial clock runs only inside frames.
*/
// Behaviour
// - An over-current on any switch latches that switch's flag and turns that gate off.
// - Any latched switch over-current also shows as the combined fault in the status byte.
// - A switch tripped by over-current stays off until the host clears its flag.
// - Supply under-voltage turns all gates off at once and latches its flag.
// - With under-voltage auto-recovery enabled, gates come back when the supply is valid again.
// - Supply over-voltage turns all gates off at once and latches its flag.
// - With over-voltage auto-recovery enabled, gates come back when the supply is valid again.
// - The rise dead-time code selects 250 ns times code plus one.
// - The fall dead-time code selects 250 ns times code plus one.
// - The trip level code selects 0.25 V times code plus one for all switches.
// - Dual half-bridge mode ignores modulation and freewheel settings.
// - The slew bit picks slow slew at 0 and the typical rate at 1.
// - With under-voltage recovery disabled, gates stay off until the host clears the flag.
// - With over-voltage recovery disabled, gates stay off until the host clears the flag.
// - A read-and-clear access returns the status word and then clears it.
`timescale 1ns/1ps
module bpsc_top
   import bpsc_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        sclk_in,
   input  wire logic        csn_in,
   input  wire logic        sdi_in,
   output logic        sdo_out,
   output logic        sdo_oe_out,
   input  wire logic [3:0]  switch_overcurrent_in,
   input  wire logic        supply_undervoltage_in,
   input  wire logic        supply_overvoltage_in,
   input  wire logic        undervoltage_autorecover_disable_in,
   input  wire logic        overvoltage_autorecover_disable_in,
   input  wire logic        freewheel_side_select_in,
   input  wire logic        freewheel_active_select_in,
   input  wire logic        pwm_in,
   input  wire logic [3:0]  gate_request_in,
   output logic [3:0]  gate_enable_out,
   output logic [3:0]  rise_dead_time_code_out,
   output logic [3:0]  fall_dead_time_code_out,
   output logic [8:0]  rise_dead_cycles_out,
   output logic [8:0]  fall_dead_cycles_out,
   output logic [2:0]  current_trip_level_code_out,
   output logic [11:0] current_trip_mv_out,
   output logic        dual_half_bridge_select_out,
   output logic        gate_slew_select_out,
   output logic        pwm_used_out,
   output logic        freewheel_side_used_out,
   output logic        freewheel_active_used_out,
   output logic [15:0] fault_status_out
);
   typedef enum logic [1:0] {
      BPSC_IDLE  = 2'b00,
      BPSC_FRAME = 2'b01,
      BPSC_DONE  = 2'b10
   } bpsc_frame_t;

   logic [3:0]  oc_sync;
   logic        uv_sync;
   logic        ov_sync;
   logic        csn_sync;
   logic        cs_active_sync;
   logic [5:0]  read_addr;
   logic        csn_q_ff;
   logic [3:0]  switch_overcurrent_flag_ff;
   logic        supply_undervoltage_flag_ff;
   logic        supply_overvoltage_flag_ff;
   logic [15:0] bridge_cfg_ff;
   logic [3:0]  gate_enable_ff;
   logic        sdo_oe_ff;
   bpsc_frame_t frame_state_ff;
   bpsc_frame_t nxt_frame_state;
   logic [23:0] frame_word;
   logic [4:0]  bit_count;
   logic [15:0] status_word;
   logic [15:0] read_word;
   logic [7:0]  status_byte;
   logic        combined_supply_current_fault;
   logic        frame_commit;
   logic        do_write;
   logic        do_clear;
   logic [5:0]  frame_addr;
   logic [1:0]  frame_op;

   function automatic logic [8:0] dead_cycles(input logic [3:0] code);
      dead_cycles = 9'((int'(code) + 1) * DEAD_STEP_CYCLES);
   endfunction

   bpsc_sync #(.WIDTH(7)) u_sync (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .d_in     ({switch_overcurrent_in, supply_undervoltage_in,
                  supply_overvoltage_in, !csn_in}),
      .q_out    ({oc_sync, uv_sync, ov_sync, cs_active_sync})
   );

   // Inverted so that the synchroniser's reset value reads as an idle bus
   assign csn_sync = !cs_active_sync;

   // Outgoing data is read across domains; it is stable in the frame
   // because the link loads the status byte at the first fall and the data word at the eighth.
   bpsc_link u_link (
      .sclk_in        (sclk_in),
      .csn_in         (csn_in),
      .sdi_in         (sdi_in),
      .status_byte_in (status_byte),
      .read_word_in   (read_word),
      .frame_out      (frame_word),
      .bit_count_out  (bit_count),
      .sdo_out        (sdo_out)
   );

   assign status_word = {6'h00, switch_overcurrent_flag_ff, 2'h0,
                         supply_undervoltage_flag_ff, supply_overvoltage_flag_ff,
                         2'h0} & FAULT_STATUS_MASK;
   assign combined_supply_current_fault = (|switch_overcurrent_flag_ff)
                                        | supply_undervoltage_flag_ff
                                        | supply_overvoltage_flag_ff;
   assign status_byte = {combined_supply_current_fault, 4'h0,
                         combined_supply_current_fault, 2'h0};
   assign frame_addr  = frame_word[21:16];
   assign frame_op    = frame_word[23:22];
   // After eight bits the address sits at the low end of the live word
   assign read_addr   = frame_word[5:0];

   always_comb begin
      read_word = 16'h0000;
      if (read_addr == ADDR_FAULT_STATUS)
         read_word = status_word;
      else if (read_addr == ADDR_BRIDGE_CFG)
         read_word = bridge_cfg_ff & BRIDGE_CFG_MASK;
   end

   // Frame ends on chip select rise; the frame is read only after that,
   // when the serial side is quiet. Frames not of 24 bits are ignored.
   always_comb begin
      nxt_frame_state = frame_state_ff;
      unique case (frame_state_ff)
         BPSC_IDLE:  if (!csn_sync) nxt_frame_state = BPSC_FRAME;
         BPSC_FRAME: if (csn_sync)  nxt_frame_state = BPSC_DONE;
         BPSC_DONE:  nxt_frame_state = BPSC_IDLE;
         default:    nxt_frame_state = BPSC_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in)
         frame_state_ff <= BPSC_IDLE;
      else
         frame_state_ff <= nxt_frame_state;
   end

   // The link holds the finished frame from chip select rise, so the late
   // look from this domain still sees the final count.
   always_ff @(posedge clk_in) begin
      if (!rst_b_in)
         csn_q_ff <= 1'b1;
      else
         csn_q_ff <= csn_sync;
   end

   assign frame_commit = (frame_state_ff == BPSC_FRAME) && csn_sync && !csn_q_ff
                       && (bit_count == 5'(FRAME_BITS))
                       && (frame_word != 24'hFFFFFF);
   assign do_write = frame_commit && (frame_op == OP_WRITE);
   assign do_clear = frame_commit && (frame_op == OP_READ_CLEAR)
                   && (frame_addr == ADDR_FAULT_STATUS);

   always_ff @(posedge clk_in) begin
      if (!rst_b_in)
         bridge_cfg_ff <= BRIDGE_CFG_RST;
      else if (do_write && (frame_addr == ADDR_BRIDGE_CFG))
         bridge_cfg_ff <= frame_word[15:0] & BRIDGE_CFG_MASK;
   end

   // New faults win over a clear in the same cycle
   always_ff @(posedge clk_in) begin
      if (!rst_b_in)
         switch_overcurrent_flag_ff <= FAULT_STATUS_RST[POS_HIGH_SWITCH_ONE:POS_LOW_SWITCH_TWO];
      else
         switch_overcurrent_flag_ff <= (do_clear ? 4'h0 : switch_overcurrent_flag_ff)
                                     | oc_sync;
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         supply_undervoltage_flag_ff <= FAULT_STATUS_RST[POS_UNDERVOLTAGE];
         supply_overvoltage_flag_ff  <= FAULT_STATUS_RST[POS_OVERVOLTAGE];
      end else begin
         supply_undervoltage_flag_ff <= (supply_undervoltage_flag_ff && !do_clear)
                                      | uv_sync;
         supply_overvoltage_flag_ff  <= (supply_overvoltage_flag_ff && !do_clear)
                                      | ov_sync;
      end
   end

   // Gate order: high one, low one, high two, low two
   always_ff @(posedge clk_in) begin
      logic supply_block;
      supply_block = 1'b0;
      if (!rst_b_in) begin
         gate_enable_ff <= 4'h0;
      end else begin
         supply_block = uv_sync || ov_sync
                      || (undervoltage_autorecover_disable_in
                          && supply_undervoltage_flag_ff)
                      || (overvoltage_autorecover_disable_in
                          && supply_overvoltage_flag_ff);
         gate_enable_ff <= supply_block ? 4'h0
                         : gate_request_in & ~switch_overcurrent_flag_ff
                           & ~oc_sync;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in)
         sdo_oe_ff <= 1'b0;
      else
         sdo_oe_ff <= !csn_sync;
   end

   assign gate_enable_out             = gate_enable_ff;
   assign sdo_oe_out                  = sdo_oe_ff;
   assign rise_dead_time_code_out     = bridge_cfg_ff[POS_RISE_DEAD_LSB +: 4];
   assign fall_dead_time_code_out     = bridge_cfg_ff[POS_FALL_DEAD_LSB +: 4];
   assign rise_dead_cycles_out        = dead_cycles(rise_dead_time_code_out);
   assign fall_dead_cycles_out        = dead_cycles(fall_dead_time_code_out);
   assign current_trip_level_code_out = bridge_cfg_ff[POS_TRIP_LEVEL_LSB +: 3];
   assign current_trip_mv_out         = 12'((int'(current_trip_level_code_out) + 1)
                                          * TRIP_STEP_MV);
   assign dual_half_bridge_select_out = bridge_cfg_ff[POS_DUAL_HALF];
   assign gate_slew_select_out        = bridge_cfg_ff[POS_GATE_SLEW];
   assign pwm_used_out                = dual_half_bridge_select_out ? 1'b1 : pwm_in;
   assign freewheel_side_used_out     = !dual_half_bridge_select_out
                                      && freewheel_side_select_in;
   assign freewheel_active_used_out   = !dual_half_bridge_select_out
                                      && freewheel_active_select_in;
   assign fault_status_out            = status_word;
endmodule

// >>> verification/bpsc_host.sv
/*
 Host serial master model: 24-bit frames, serial clock of 12 ns period.
 Assumes the device samples on rising edges and shifts on falling edges.
*/
`timescale 1ns/1ps
module bpsc_host (
   input  wire logic sdo_in,
   input  wire logic sdo_oe_in,
   output logic      sclk_out,
   output logic      csn_out,
   output logic      sdi_out
);
   initial begin
      sclk_out = 1'b0;
      csn_out  = 1'b0;
      sdi_out  = 1'b0;
      // A sure rising edge resets the link's counters before the first frame
      #1 csn_out = 1'b1;
   end
   // Clock stands still outside frames; a released output reads as unknown
   task automatic xfer(input logic [23:0] word, output logic [23:0] rd);
      csn_out = 1'b0;
      #40;
      for (int i = 23; i >= 0; i--) begin
         sdi_out = word[i];
         // Taken just before the rise, well after the falling edge that shifted it
         #6 rd[i] = sdo_oe_in ? sdo_in : 1'bx;
         sclk_out = 1'b1;
         #6 sclk_out = 1'b0;
      end
      #6 csn_out = 1'b1;
      sdi_out = ~sdi_out;
      #80;
   endtask
endmodule

// >>> verification/bpsc_chk.sv
/*
 Checker for the status and configuration bank, bound to the top module.
 Assumes one core clock domain with synchronous active-low reset.
*/
`timescale 1ns/1ps
module bpsc_chk
   import bpsc_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        rst_b_in,
   input wire logic [3:0]  switch_overcurrent_in,
   input wire logic        supply_undervoltage_in,
   input wire logic        supply_overvoltage_in,
   input wire logic        undervoltage_autorecover_disable_in,
   input wire logic        overvoltage_autorecover_disable_in,
   input wire logic [3:0]  gate_enable_out,
   input wire logic [3:0]  rise_dead_time_code_out,
   input wire logic [8:0]  rise_dead_cycles_out,
   input wire logic [2:0]  current_trip_level_code_out,
   input wire logic [11:0] current_trip_mv_out,
   input wire logic        dual_half_bridge_select_out,
   input wire logic        pwm_used_out,
   input wire logic        freewheel_side_used_out,
   input wire logic        freewheel_active_used_out,
   input wire logic [15:0] fault_status_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   // Synchronisers allow three cycles of lag, so the supply must hold four
   sequence uv_held; supply_undervoltage_in [*4]; endsequence
   sequence ov_held; supply_overvoltage_in [*4]; endsequence
   oc_flag_set_a: assert property (switch_overcurrent_in[3] |-> ##[1:4] fault_status_out[9])
      else $error("over-current flag not latched");
   oc_gate_off_a: assert property (fault_status_out[9] && $past(fault_status_out[9]) |-> !gate_enable_out[3])
      else $error("tripped gate still enabled");
   uv_gates_off_a: assert property (uv_held |-> gate_enable_out == 4'h0)
      else $error("gates on during under-voltage");
   ov_gates_off_a: assert property (ov_held |-> gate_enable_out == 4'h0)
      else $error("gates on during over-voltage");
   uv_hold_off_a: assert property (undervoltage_autorecover_disable_in && fault_status_out[3]
      && $past(fault_status_out[3]) |-> gate_enable_out == 4'h0)
      else $error("gates back before under-voltage flag cleared");
   ov_hold_off_a: assert property (overvoltage_autorecover_disable_in && fault_status_out[2]
      && $past(fault_status_out[2]) |-> gate_enable_out == 4'h0)
      else $error("gates back before over-voltage flag cleared");
   // Wide arithmetic so that a truncated count is seen
   rise_dead_a: assert property ($stable(rise_dead_time_code_out) |->
      {3'h0, rise_dead_cycles_out} == (12'(rise_dead_time_code_out) + 12'h001) * 12'h019)
      else $error("rise dead cycles wrong");
   trip_level_a: assert property ($stable(current_trip_level_code_out) |->
      current_trip_mv_out == (12'(current_trip_level_code_out) + 12'h001) * 12'h0FA)
      else $error("trip level wrong");
   half_mode_a: assert property (dual_half_bridge_select_out && $past(dual_half_bridge_select_out)
      |-> pwm_used_out && !freewheel_side_used_out && !freewheel_active_used_out)
      else $error("half-bridge mode uses modulation or freewheel");
   status_mask_a: assert property ((fault_status_out & ~FAULT_STATUS_MASK) == 16'h0000)
      else $error("reserved status bit set");
endmodule

bind bpsc_top bpsc_chk bpsc_chk_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
   .switch_overcurrent_in(switch_overcurrent_in), .supply_undervoltage_in(supply_undervoltage_in),
   .supply_overvoltage_in(supply_overvoltage_in),
   .undervoltage_autorecover_disable_in(undervoltage_autorecover_disable_in),
   .overvoltage_autorecover_disable_in(overvoltage_autorecover_disable_in),
   .gate_enable_out(gate_enable_out), .rise_dead_time_code_out(rise_dead_time_code_out),
   .rise_dead_cycles_out(rise_dead_cycles_out),
   .current_trip_level_code_out(current_trip_level_code_out),
   .current_trip_mv_out(current_trip_mv_out),
   .dual_half_bridge_select_out(dual_half_bridge_select_out), .pwm_used_out(pwm_used_out),
   .freewheel_side_used_out(freewheel_side_used_out),
   .freewheel_active_used_out(freewheel_active_used_out), .fault_status_out(fault_status_out));

// >>> verification/tb_top.sv
/*
 Self-checking bench: host model drives frames, faults driven at falling edges.
 Assumes the bank answers reads with the status byte then the data word.
*/
`timescale 1ns/1ps
module tb_top;
   import bpsc_pkg::*;
   logic        clk_in   = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        sclk, csn, sdi, sdo, sdo_oe, half, slew, pwm_u, fws_u, fwa_u;
   logic        uv = 1'b0, ov = 1'b0, uvd = 1'b0, ovd = 1'b0;
   logic        fws = 1'b0, freewheel_active_select = 1'b0, pwm = 1'b0;
   logic [3:0]  oc = 4'h0, req = 4'h0, gate, rcode, fcode;
   logic [8:0]  rcyc, fcyc;
   logic [2:0]  tcode;
   logic [11:0] tmv;
   logic [15:0] fstat, v, flag;
   logic [23:0] rd_word, exp_q[$];
   logic [31:0] seed = 32'd72104;
   int          errors = 0, cmp_count = 0;
   event        got;
   always #5 clk_in = ~clk_in;
   bpsc_host bpsc_host_i (.sdo_in(sdo), .sdo_oe_in(sdo_oe), .sclk_out(sclk), .csn_out(csn),
      .sdi_out(sdi));
   bpsc_top bpsc_top_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .sclk_in(sclk), .csn_in(csn),
      .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .switch_overcurrent_in(oc),
      .supply_undervoltage_in(uv), .supply_overvoltage_in(ov),
      .undervoltage_autorecover_disable_in(uvd), .overvoltage_autorecover_disable_in(ovd),
      .freewheel_side_select_in(fws), .freewheel_active_select_in(freewheel_active_select), .pwm_in(pwm),
      .gate_request_in(req), .gate_enable_out(gate), .rise_dead_time_code_out(rcode),
      .fall_dead_time_code_out(fcode), .rise_dead_cycles_out(rcyc), .fall_dead_cycles_out(fcyc),
      .current_trip_level_code_out(tcode), .current_trip_mv_out(tmv),
      .dual_half_bridge_select_out(half), .gate_slew_select_out(slew), .pwm_used_out(pwm_u),
      .freewheel_side_used_out(fws_u), .freewheel_active_used_out(fwa_u),
      .fault_status_out(fstat));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   function automatic logic [7:0] sb(input logic f);
      return {f, 4'h0, f, 2'h0};
   endfunction
   task automatic complete_run();
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Expected word is queued before the frame; the watcher compares it
   task automatic spi(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d,
                      input bit chk, input logic [23:0] exp);
      logic [23:0] rd;
      if (chk) exp_q.push_back(exp);
      bpsc_host_i.xfer({op, a, d}, rd);
      rd_word = rd;
      if (chk) ->got;
      @(negedge clk_in);
   endtask
   always @(got) check("read word", rd_word, exp_q.pop_front());
   task automatic wait_gate(input logic [3:0] exp);
      int n;
      n = 0;
      while (gate !== exp && n < 60) begin
         @(negedge clk_in);
         n++;
      end
      check("gate enable", gate, exp);
      if (gate !== exp) complete_run();
   endtask
   initial begin
      repeat (4) @(negedge clk_in);
      rst_b_in = 1'b1;
      repeat (4) @(negedge clk_in);
      spi(OP_READ, ADDR_BRIDGE_CFG, 16'h0000, 1, {8'h00, BRIDGE_CFG_RST});
      spi(OP_READ, ADDR_FAULT_STATUS, 16'h0000, 1, {8'h00, FAULT_STATUS_RST});
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         v = (k == 5) ? 16'hFFFF : seed[15:0];
         {pwm, fws, freewheel_active_select} = seed[18:16];
         spi(OP_WRITE, ADDR_BRIDGE_CFG, v, 0, 24'h000000);
         check("codes", {rcode, fcode, tcode}, {v[15:12], v[11:8], v[7:5]});
         spi(OP_READ, ADDR_BRIDGE_CFG, 16'h0000, 1, {8'h00, v & BRIDGE_CFG_MASK});
         check("rise cycles", rcyc, (v[15:12] + 24'h1) * 24'd25);
         check("fall cycles", fcyc, (v[11:8] + 24'h1) * 24'd25);
         check("trip mv", tmv, (v[7:5] + 24'h1) * 24'd250);
         check("slew", slew, v[3]);
         check("half", half, v[4]);
         check("pwm used", pwm_u, v[4] | pwm);
         check("freewheel used", {fws_u, fwa_u}, {fws, freewheel_active_select} & {2{~v[4]}});
      end
      // Unmapped place: write ignored, read gives zero
      spi(OP_WRITE, 6'h05, 16'h1234, 0, 24'h000000);
      spi(OP_READ, 6'h05, 16'h0000, 1, 24'h000000);
      spi(OP_READ, ADDR_BRIDGE_CFG, 16'h0000, 1, {8'h00, BRIDGE_CFG_MASK});
      for (int k = 0; k < 4; k++) begin
         req = 4'h1 << k;
         wait_gate(req);
         oc[k] = 1'b1;
         wait_gate(4'h0);
         oc[k] = 1'b0;
         repeat (10) @(negedge clk_in);
         check("gate held off", gate, 4'h0);
         check("oc flag", fstat, 16'h0040 << k);
         spi(OP_READ_CLEAR, ADDR_FAULT_STATUS, 16'h0000, 1, {sb(1), 16'h0040 << k});
         spi(OP_READ, ADDR_FAULT_STATUS, 16'h0000, 1, {sb(0), 16'h0000});
         wait_gate(req);
      end
      // High switches only, so no shoot-through interlock hides the result
      req = 4'hA;
      for (int j = 0; j < 4; j++) begin
         uvd = j[1];
         ovd = j[1];
         wait_gate(4'hA);
         if (j[0]) ov = 1'b1;
         else uv = 1'b1;
         wait_gate(4'h0);
         // Fault held past the synchroniser lag so the held-supply checks engage
         repeat (4) @(negedge clk_in);
         uv = 1'b0;
         ov = 1'b0;
         flag = j[0] ? 16'h0004 : 16'h0008;
         repeat (10) @(negedge clk_in);
         check("supply flag", fstat, flag);
         check("gate after supply", gate, j[1] ? 4'h0 : 4'hA);
         spi(OP_READ_CLEAR, ADDR_FAULT_STATUS, 16'h0000, 1, {sb(1), flag});
         wait_gate(4'hA);
      end
      complete_run();
   end
endmodule
